// ### hcsu_core.sv
// host command and status unit: serial slave, command decoder, status bytes
`timescale 1ns/1ps
module hcsu_core #(
    parameter int         GPIO_W   = 16,
    parameter logic [7:0] MAKER_ID = 8'h5a,  // arbitrary value
    parameter logic [7:0] REVISION = 8'h01   // arbitrary value
) (
    input  wire logic               sys_clk,
    input  wire logic               rst_n,
    input  wire logic               scl_i,
    output logic                    scl_o,
    output logic                    scl_oe,
    input  wire logic               sda_i,
    output logic                    sda_o,
    output logic                    sda_oe,
    input  wire logic [1:0]         addr_strap,
    input  wire hcsu_pkg::hcsu_evt_s evt,
    input  wire logic               core_busy,
    input  wire logic               halt_enter,
    output logic                    core_halted,
    input  wire logic [GPIO_W-1:0]  gpio_i,
    output logic [GPIO_W-1:0]       gpio_o,
    output logic [GPIO_W-1:0]       gpio_oe,
    output logic [GPIO_W-1:0]       gpio_pull_en,
    output logic [GPIO_W-1:0]       gpio_pull_down,
    output logic                    irq_o,
    output logic                    irq_oe,
    output logic [7:0]              cfg,
    output logic                    sw_reset
);
    import hcsu_pkg::*;

    localparam int SW = GPIO_W + 4;

    generate
        if (GPIO_W < 1 || GPIO_W > 16) begin : g_bad_width
            $error("GPIO_W must lie between 1 and 16");
        end
    endgenerate

    logic [SW-1:0]     s1_q, s2_q, s3_q, filt_q;
    logic              scl_f, sda_f, scl_p_q, sda_p_q;
    logic [GPIO_W-1:0] pins_f;
    logic [1:0]        strap_f;
    logic [2:0]        strap_cnt_q;
    logic [6:0]        my_addr_q;
    hcsu_state_e       state_q;
    logic [2:0]        bit_q;
    logic [7:0]        shift_q;
    logic [1:0]        byte_q;
    logic              rw_q, ph_q;
    logic [7:0]        cmd_q, hi_q;
    logic              halted_q, wake_q;
    logic [7:0]        int_q, err_q, int_d, err_d, int_set, err_set, cause;
    logic              setup_q, setup_d;
    logic              scl_rise, scl_fall, start_c, stop_c, activity;
    logic              rx_done, ld, addr_done, addr_hit;
    logic [7:0]        rx_byte, tx_c;
    logic [15:0]       dir16, pin16;
    logic              known, opc_bad, arg_bad, soft_go, cfg_wr, soft_q;

    // pins: three stages, a change counts once stages two and three agree
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s1_q   <= '1;
            s2_q   <= '1;
            s3_q   <= '1;
            filt_q <= '1;
        end else begin
            s1_q   <= {addr_strap, gpio_i, sda_i, scl_i};
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
        end
    end

    assign scl_f   = filt_q[0];
    assign sda_f   = filt_q[1];
    assign pins_f  = filt_q[GPIO_W+1:2];
    assign strap_f = filt_q[SW-1:SW-2];

    // straps are caught once the synchroniser has settled after release
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            strap_cnt_q <= '0;
            my_addr_q   <= ADDR_BASE;
        end else if (strap_cnt_q != STRAP_WAIT) begin
            strap_cnt_q <= strap_cnt_q + 3'h1;
            my_addr_q   <= ADDR_BASE + {5'h00, strap_f};
        end
    end

    // bus edges and start/stop conditions on the filtered levels
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_f;
            sda_p_q <= sda_f;
        end
    end

    assign scl_rise  = scl_f & ~scl_p_q;
    assign scl_fall  = ~scl_f & scl_p_q;
    assign start_c   = scl_f & scl_p_q & sda_p_q & ~sda_f;
    assign stop_c    = scl_f & scl_p_q & ~sda_p_q & sda_f;
    assign activity  = start_c | scl_fall | (sda_f ^ sda_p_q);
    assign rx_byte   = {shift_q[6:0], sda_f};
    assign addr_done = (state_q == ST_ADDR) & scl_rise & (bit_q == BIT_LAST);
    // a start byte carries address zero and never matches
    assign addr_hit  = (rx_byte[7:1] == my_addr_q) & ~wake_q;
    assign rx_done   = (state_q == ST_WBYTE) & scl_rise & (bit_q == BIT_LAST);
    assign ld = scl_fall & ph_q & (((state_q == ST_AACK) & rw_q) | (state_q == ST_RACK));

    // command decode on the first written byte, key and config checks on the second
    assign known   = (rx_byte >= CMD_FIRST) & (rx_byte <= CMD_LAST) & (rx_byte != CMD_HOLE);
    assign opc_bad = rx_done & (byte_q == IDX_CMD) & ~known;
    assign soft_go = rx_done & (byte_q == IDX_HI) & (cmd_q == CMD_SOFT_RST)
                     & (rx_byte == RST_KEY);
    assign arg_bad = rx_done & (byte_q == IDX_HI) & (cmd_q == CMD_SOFT_RST)
                     & (rx_byte != RST_KEY);
    assign cfg_wr  = rx_done & (byte_q == IDX_HI) & (cmd_q == CMD_CFG_WR);

    // halt and wake: the first address after waking is left unacked
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            halted_q <= 1'b0;
            wake_q   <= 1'b0;
        end else if (halted_q && activity) begin
            halted_q <= 1'b0;
            wake_q   <= 1'b1;
        end else if (halt_enter && state_q == ST_IDLE) begin
            halted_q <= 1'b1;
        end else if (addr_done) begin
            wake_q   <= 1'b0;
        end
    end

    // clock stretch: hold the clock low after a falling edge while busy
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            scl_oe <= 1'b0;
        end else if (scl_fall && core_busy) begin
            scl_oe <= 1'b1;
        end else if (!core_busy) begin
            scl_oe <= 1'b0;
        end
    end

    // open-drain pins only ever pull low
    always_ff @(posedge sys_clk) begin
        scl_o       <= 1'b0;
        sda_o       <= 1'b0;
        core_halted <= halted_q;
    end

    // serial slave: bit shifting, acknowledge and transmit
    always_ff @(posedge sys_clk) begin
        if (!rst_n || soft_q) begin
            state_q <= ST_IDLE;
            bit_q   <= '0;
            shift_q <= '0;
            byte_q  <= '0;
            rw_q    <= 1'b0;
            ph_q    <= 1'b0;
            sda_oe  <= 1'b0;
        end else if (stop_c) begin
            state_q <= ST_IDLE;
            sda_oe  <= 1'b0;
        end else if (start_c) begin
            state_q <= ST_ADDR;
            bit_q   <= '0;
            byte_q  <= IDX_CMD;
            ph_q    <= 1'b0;
            sda_oe  <= 1'b0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        shift_q <= rx_byte;
                        bit_q   <= bit_q + 3'h1;
                        if (bit_q == BIT_LAST) begin
                            rw_q    <= sda_f;
                            state_q <= addr_hit ? ST_AACK : ST_IDLE;
                        end
                    end
                end
                ST_AACK, ST_WACK: begin
                    if (scl_fall && !ph_q) begin
                        sda_oe <= 1'b1;
                        ph_q   <= 1'b1;
                    end else if (scl_fall) begin
                        ph_q  <= 1'b0;
                        bit_q <= '0;
                        if (state_q == ST_AACK && rw_q) begin
                            shift_q <= tx_c;
                            sda_oe  <= ~tx_c[7];
                            state_q <= ST_RBYTE;
                        end else begin
                            sda_oe  <= 1'b0;
                            state_q <= ST_WBYTE;
                        end
                    end
                end
                ST_WBYTE: begin
                    if (scl_rise) begin
                        shift_q <= rx_byte;
                        bit_q   <= bit_q + 3'h1;
                        if (bit_q == BIT_LAST) begin
                            state_q <= ST_WACK;
                            if (byte_q != IDX_MAX) byte_q <= byte_q + 2'h1;
                        end
                    end
                end
                ST_RBYTE: begin
                    if (scl_fall && bit_q == BIT_LAST) begin
                        sda_oe  <= 1'b0;
                        state_q <= ST_RACK;
                    end else if (scl_fall) begin
                        bit_q   <= bit_q + 3'h1;
                        shift_q <= {shift_q[6:0], 1'b0};
                        sda_oe  <= ~shift_q[6];
                    end
                end
                ST_RACK: begin
                    // a nack from the host ends the read
                    if (scl_rise && sda_f) begin
                        state_q <= ST_IDLE;
                    end else if (scl_rise) begin
                        ph_q <= 1'b1;
                    end else if (scl_fall && ph_q) begin
                        ph_q    <= 1'b0;
                        bit_q   <= '0;
                        shift_q <= tx_c;
                        sda_oe  <= ~tx_c[7];
                        state_q <= ST_RBYTE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    sda_oe  <= 1'b0;
                end
            endcase
            if (ld && byte_q != IDX_MAX) byte_q <= byte_q + 2'h1;
        end
    end

    // the command byte stays valid across a repeated start
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cmd_q <= '0;
        end else if (rx_done && byte_q == IDX_CMD) begin
            cmd_q <= known ? rx_byte : 8'h00;
        end
    end

    // read data: two-byte words go high byte first
    always_comb begin
        dir16 = '0;
        pin16 = '0;
        dir16[GPIO_W-1:0] = gpio_oe;
        pin16[GPIO_W-1:0] = pins_f;
    end

    always_comb begin
        case (cmd_q)
            CMD_IDENT:  tx_c = (byte_q == IDX_CMD) ? MAKER_ID : REVISION;
            CMD_INT_RD: tx_c = cause;
            CMD_ERR_RD: tx_c = err_q;
            CMD_DIR_RD: tx_c = (byte_q == IDX_CMD) ? dir16[15:8] : dir16[7:0];
            CMD_PIN_RD: tx_c = (byte_q == IDX_CMD) ? pin16[15:8] : pin16[7:0];
            default:    tx_c = 8'h00;
        endcase
    end

    // event collection: a set in the clearing cycle wins
    always_comb begin
        err_set            = '0;
        err_set[ERR_ARG]   = arg_bad;
        err_set[ERR_OPC]   = opc_bad;
        err_set[ERR_KEYS]  = evt.too_many_keys;
        err_set[ERR_QUEUE] = evt.queue_overflow;
        int_set                   = '0;
        int_set[INT_SCR0 +: 3]    = evt.script_done;
        int_set[INT_ERR]          = |err_set;
        int_set[INT_ENC]          = evt.encoder_change;
        int_set[INT_KEY]          = evt.key_event;
        int_d = (ld && cmd_q == CMD_INT_RD && byte_q == IDX_CMD) ? int_set
                : (int_q | int_set);
        err_d = (ld && cmd_q == CMD_ERR_RD && byte_q == IDX_CMD) ? err_set
                : (err_q | err_set);
        // setup flag ignores status reads, only a config write clears it
        setup_d = soft_go | (setup_q & ~cfg_wr);
    end

    // bit 2 and bit 4 never enter the sticky byte
    assign cause = int_q | ({7'h00, setup_q} << INT_SETUP);

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            int_q   <= '0;
            err_q   <= '0;
            setup_q <= 1'b1;
        end else begin
            int_q   <= int_d;
            err_q   <= err_d;
            setup_q <= setup_d;
        end
    end

    // request pin: low while any cause is pending; drive mode from config
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irq_o  <= 1'b0;
            irq_oe <= 1'b1;
        end else begin
            irq_o  <= ~(|int_d | setup_d);
            irq_oe <= (|int_d | setup_d) | cfg[CFG_PUSHPULL];
        end
    end

    // soft reset pulse, also sent to the rest of the device
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            soft_q   <= 1'b0;
            sw_reset <= 1'b0;
        end else begin
            soft_q   <= soft_go;
            sw_reset <= soft_go;
        end
    end

    // configuration register, reloaded by soft reset
    always_ff @(posedge sys_clk) begin
        if (!rst_n || soft_q) begin
            cfg <= CFG_RESET;
        end else if (cfg_wr) begin
            cfg <= rx_byte;
        end
    end

    // pin setup: the high byte waits in hi_q until the low byte lands
    always_ff @(posedge sys_clk) begin
        if (!rst_n || soft_q) begin
            hi_q           <= '0;
            gpio_o         <= '0;
            gpio_oe        <= '0;
            gpio_pull_down <= '0;
            gpio_pull_en   <= '0;
        end else begin
            gpio_pull_en <= ~gpio_oe & gpio_o;
            if (rx_done && byte_q == IDX_HI) begin
                hi_q <= rx_byte;
            end
            if (rx_done && byte_q == IDX_LO) begin
                unique case (cmd_q)
                    CMD_PULL_WR: gpio_pull_down <= GPIO_W'({hi_q, rx_byte});
                    CMD_DIR_WR:  gpio_oe        <= GPIO_W'({hi_q, rx_byte});
                    CMD_LVL_WR:  gpio_o         <= GPIO_W'({hi_q, rx_byte});
                    default:     hi_q           <= hi_q;
                endcase
            end
        end
    end
endmodule

// ### hcsu_pkg.sv
// constants, types and command codes for the host command and status unit
package hcsu_pkg;
    // command codes
    localparam logic [7:0] CMD_IDENT    = 8'h80;
    localparam logic [7:0] CMD_CFG_WR   = 8'h81;
    localparam logic [7:0] CMD_INT_RD   = 8'h82;
    localparam logic [7:0] CMD_SOFT_RST = 8'h83;
    localparam logic [7:0] CMD_PULL_WR  = 8'h84;
    localparam logic [7:0] CMD_DIR_WR   = 8'h85;
    localparam logic [7:0] CMD_LVL_WR   = 8'h86;
    localparam logic [7:0] CMD_DIR_RD   = 8'h87;
    localparam logic [7:0] CMD_PIN_RD   = 8'h88;
    localparam logic [7:0] CMD_ERR_RD   = 8'h8c;
    localparam logic [7:0] CMD_FIRST    = 8'h80;
    localparam logic [7:0] CMD_LAST     = 8'h97;
    localparam logic [7:0] CMD_HOLE     = 8'h8d;
    localparam logic [7:0] RST_KEY      = 8'haa;
    // configuration register
    localparam logic [7:0] CFG_RESET    = 8'h80;
    localparam int         CFG_PUSHPULL = 7;
    // slave address base, strap value is added
    localparam logic [6:0] ADDR_BASE    = 7'h42;
    localparam logic [2:0] STRAP_WAIT   = 3'h5;
    // interrupt cause bit positions
    localparam int INT_KEY   = 0;
    localparam int INT_ENC   = 1;
    localparam int INT_ERR   = 3;
    localparam int INT_SETUP = 4;
    localparam int INT_SCR0  = 5;
    // error cause bit positions
    localparam int ERR_ARG   = 0;
    localparam int ERR_OPC   = 1;
    localparam int ERR_KEYS  = 2;
    localparam int ERR_QUEUE = 6;
    // data byte positions within a command
    localparam logic [1:0] IDX_CMD  = 2'h0;
    localparam logic [1:0] IDX_HI   = 2'h1;
    localparam logic [1:0] IDX_LO   = 2'h2;
    localparam logic [1:0] IDX_MAX  = 2'h3;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // event strobes from the rest of the device, one cycle each
    typedef struct packed {
        logic [2:0] script_done;
        logic       encoder_change;
        logic       key_event;
        logic       queue_overflow;
        logic       too_many_keys;
    } hcsu_evt_s;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_ADDR  = 7'h02,
        ST_AACK  = 7'h04,
        ST_WBYTE = 7'h08,
        ST_WACK  = 7'h10,
        ST_RBYTE = 7'h20,
        ST_RACK  = 7'h40
    } hcsu_state_e;
endpackage

// ### hcsu_core_props.sv
// assertion checker for the host command and status unit ports
`timescale 1ns/1ps
module hcsu_core_props
    import hcsu_pkg::*;
#(
    parameter int GPIO_W = 16
) (
    input wire logic                sys_clk,
    input wire logic                rst_n,
    input wire logic                scl_i,
    input wire logic                scl_o,
    input wire logic                scl_oe,
    input wire logic                sda_o,
    input wire logic                sda_oe,
    input wire hcsu_pkg::hcsu_evt_s evt,
    input wire logic                core_busy,
    input wire logic                core_halted,
    input wire logic [GPIO_W-1:0]   gpio_o,
    input wire logic [GPIO_W-1:0]   gpio_oe,
    input wire logic [GPIO_W-1:0]   gpio_pull_en,
    input wire logic                irq_o,
    input wire logic                irq_oe,
    input wire logic [7:0]          cfg,
    input wire logic                sw_reset
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // an event pulse lands in the cause byte and pulls the request low at the same edge
    sequence s_event;
        evt != '0;
    endsequence
    sequence s_request;
        ##2 !irq_o;
    endsequence

    chk_event_request: assert property (s_event |-> s_request)
        else $error("event did not raise the request line");
    chk_request_driven: assert property (!irq_o |-> irq_oe)
        else $error("request low but pin not driven");
    chk_reset_request: assert property ($rose(rst_n) |-> !irq_o && irq_oe && cfg == CFG_RESET)
        else $error("no pending setup request after reset");
    chk_open_drain: assert property (scl_o == 1'h0 && sda_o == 1'h0)
        else $error("serial pins must only pull low");
    chk_stretch_cause: assert property ($rose(scl_oe) |-> $past(core_busy))
        else $error("clock held without busy core");
    chk_stretch_end: assert property (scl_oe && !core_busy |=> !scl_oe)
        else $error("clock held after busy dropped");
    // ack and data only move while the clock is low, never under a high clock
    chk_data_low_clk: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("data line moved while clock high");
    chk_halt_quiet: assert property (core_halted |-> !sda_oe && !scl_oe)
        else $error("halted device drove the bus");
    // soft reset clears the pins and the pull-up in the same cycle
    chk_pull_follow: assert property (
        gpio_pull_en == ($past(sw_reset) ? '0 : $past(gpio_o & ~gpio_oe)))
        else $error("weak pull-up not derived from level and direction");
    chk_soft_pulse: assert property (sw_reset |=> !sw_reset)
        else $error("soft reset longer than one cycle");
    chk_soft_cfg: assert property (sw_reset |-> ##[0:2] cfg == CFG_RESET)
        else $error("soft reset left configuration unchanged");
endmodule

// ### hcsu_host.sv
// host model: serial bus master pulling clock and data lines low
`timescale 1ns/1ps
module hcsu_host #(
    parameter int T_LO = 360,  // long low phase covers the slave's sync and filter delay
    parameter int T_HI = 240
) (
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_oe,
    output logic      sda_oe
);
    // bus idles released, clock stands still between frames
    initial begin
        scl_oe = 1'h0;
        sda_oe = 1'h0;
    end

    // release the clock and wait out any stretching by the slave
    task automatic rel_scl();
        int n;
        n = 0;
        scl_oe = 1'h0;
        while (scl_in !== 1'h1 && n < 2000) begin
            #10;
            n++;
        end
    endtask

    // one clock pulse: set data, release clock, wait out stretching, sample
    task automatic clk_bit(input logic b, output logic r);
        sda_oe = !b;
        #(T_LO);
        rel_scl();
        #(T_HI);
        r = sda_in;
        scl_oe = 1'h1;
        #80;  // data hold, so the slave never sees a false start or stop
    endtask

    task automatic start_cond();
        sda_oe = 1'h0;
        #(T_LO);
        rel_scl();
        #(T_HI);
        sda_oe = 1'h1;
        #(T_HI);
        scl_oe = 1'h1;
        #80;
    endtask

    task automatic stop_cond();
        sda_oe = 1'h1;
        #(T_LO);
        rel_scl();
        #(T_HI);
        sda_oe = 1'h0;
        #(T_HI);
    endtask

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], r);
        clk_bit(1'h1, r);
        ack = (r === 1'h0);
    endtask

    // last byte is refused so the slave lets go of the data line
    task automatic rd_byte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) clk_bit(1'h1, b[i]);
        clk_bit(last, r);
    endtask
endmodule

// ### hcsu_core_test.sv
// self-checking testbench for the host command and status unit
`timescale 1ns/1ps
module hcsu_core_test;
    import hcsu_pkg::*;
    localparam logic [7:0] MAKER = 8'h3c;  // arbitrary value
    localparam logic [7:0] REV   = 8'h07;  // arbitrary value
    localparam int         INT_OF[7] = '{8, 8, 1, 2, 32, 64, 128};
    localparam int         ERR_OF[7] = '{4, 64, 0, 0, 0, 0, 0};
    logic        sys_clk, rst_n, core_busy, halt_enter, busy_on, ok, scl_o, sda_o;
    logic        scl_oe, sda_oe, h_scl_oe, h_sda_oe, irq_o, irq_oe, sw_reset, core_halted;
    logic [1:0]  addr_strap;
    logic [6:0]  dev;
    logic [7:0]  cfg, m_cfg, op;
    logic [15:0] rd, gp, gd, gl, gpio_i, gpio_o, gpio_oe, gpio_pull_en, gpio_pull_down;
    hcsu_evt_s   evt;
    int          bad_count, n_checks, seed, sw_cnt, m_int, m_err;
    // both lines are pulled up; any driver pulls them low
    wire         scl = !(scl_oe || h_scl_oe);
    wire         sda = !(sda_oe || h_sda_oe);

    hcsu_core #(.GPIO_W(16), .MAKER_ID(MAKER), .REVISION(REV)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .addr_strap(addr_strap), .evt(evt),
        .core_busy(core_busy), .halt_enter(halt_enter), .core_halted(core_halted),
        .gpio_i(gpio_i), .gpio_o(gpio_o), .gpio_oe(gpio_oe), .gpio_pull_en(gpio_pull_en),
        .gpio_pull_down(gpio_pull_down), .irq_o(irq_o), .irq_oe(irq_oe), .cfg(cfg),
        .sw_reset(sw_reset));
    hcsu_host host (.scl_in(scl), .sda_in(sda), .scl_oe(h_scl_oe), .sda_oe(h_sda_oe));

    initial begin
        sys_clk = 1'h0;
        forever #20 sys_clk = ~sys_clk;
    end
    // random busy spells make the slave stretch the clock
    always @(posedge sys_clk) core_busy <= busy_on && ($random(seed) % 3 == 0);
    always @(posedge sys_clk) if (sw_reset === 1'h1) sw_cnt++;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        #1;  // let the edge's updates land
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // one framed transfer: write command and data, then, if nr is above zero, repeated start and read
    task automatic xfer(input logic [6:0] a, input logic [7:0] cmd, input int nw,
                        input logic [15:0] wd, input int nr, output logic [15:0] r,
                        output logic ack);
        logic       x;
        logic [7:0] b;
        r = 16'h0;
        #7;
        host.start_cond();
        host.wr_byte({a, 1'h0}, ack);
        if (ack) begin
            host.wr_byte(cmd, x);
            for (int i = nw; i > 0; i--) host.wr_byte(i == 2 ? wd[15:8] : wd[7:0], x);
            if (nr > 0) begin
                host.start_cond();
                host.wr_byte({a, 1'h1}, x);
                for (int i = nr; i > 0; i--) begin
                    host.rd_byte(i == 1, b);
                    r = {r[7:0], b};
                end
            end
        end
        host.stop_cond();
        repeat (10) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] cmd, input int nw, input logic [15:0] wd);
        xfer(dev, cmd, nw, wd, 0, rd, ok);
    endtask

    task automatic rd_chk(input logic [7:0] cmd, input int nr, input logic [15:0] exp);
        xfer(dev, cmd, 0, 16'h0, nr, rd, ok);
        check(rd, exp, "read data");
    endtask

    // model: sticky bits clear on read, setup-pending bit survives
    task automatic rd_int();
        rd_chk(CMD_INT_RD, 1, 16'(m_int));
        m_int = m_int & 8'h10;
    endtask

    task automatic rd_err();
        rd_chk(CMD_ERR_RD, 1, 16'(m_err));
        m_err = 0;
    endtask

    initial begin
        #3_500_000;
        bad_count++;
        $display("BAD at %0t: watchdog expired", $time);
        print_verdict();
    end

    initial begin
        seed = 21;
        rst_n = 1'h0;
        {halt_enter, busy_on} = 2'h0;
        evt = '0;
        gpio_i = 16'h0;
        addr_strap = 2'($random(seed));
        {bad_count, n_checks, m_err, m_int} = {32'h0, 32'h0, 32'h0, 32'h10};
        dev = ADDR_BASE + 7'(addr_strap);
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'h1;
        repeat (10) @(posedge sys_clk);
        check({cfg, 6'h0, irq_oe, irq_o}, {CFG_RESET, 8'h2}, "reset state");
        xfer(dev ^ 7'h04, CMD_IDENT, 0, 16'h0, 2, rd, ok);
        check(16'(ok), 16'h0, "foreign address acked");
        rd_chk(CMD_IDENT, 2, {MAKER, REV});
        rd_int();
        check(16'(irq_o), 16'h0, "setup request kept");
        m_cfg = 8'($random(seed));
        wr(CMD_CFG_WR, 1, 16'(m_cfg));
        m_int = 0;
        check(16'(cfg), 16'(m_cfg), "config write");
        rd_int();
        check(16'({irq_oe, irq_o}), 16'({m_cfg[CFG_PUSHPULL], 1'h1}),
              "request released");
        for (int i = 0; i < 7; i++) begin
            @(posedge sys_clk);
            evt <= hcsu_evt_s'(7'h1 << i);
            @(posedge sys_clk);
            evt <= '0;
            m_int = m_int | INT_OF[i];
            m_err = m_err | ERR_OF[i];
            repeat (3) @(posedge sys_clk);
            check(16'(irq_o), 16'h0, "request on event");
            rd_int();
            rd_err();
            rd_int();
            check(16'(irq_o), 16'h1, "request after read");
        end
        for (int k = 0; k < 2; k++) begin
            op = k == 0 ? CMD_HOLE : {1'h0, 7'($random(seed))};
            wr(op, 1, 16'($random(seed)));
            m_err = m_err | 2;
            m_int = m_int | 8;
            check(16'(cfg), 16'(m_cfg), "config after unknown code");
            rd_int();
            rd_err();
        end
        {gp, gd, gl} = {32'($random(seed)), 16'($random(seed))};
        wr(CMD_PULL_WR, 2, gp);
        check(gpio_pull_down, gp, "pull direction");
        wr(CMD_DIR_WR, 2, gd);
        check(gpio_oe, gd, "pin direction");
        rd_chk(CMD_DIR_RD, 2, gd);
        wr(CMD_LVL_WR, 2, gl);
        check(gpio_o, gl, "pin level");
        check(gpio_pull_en, gl & ~gd, "weak pull-up");
        @(posedge sys_clk);
        gpio_i <= 16'($random(seed));
        @(posedge sys_clk);
        rd_chk(CMD_PIN_RD, 2, gpio_i);
        busy_on <= 1'h1;
        rd_chk(CMD_IDENT, 2, {MAKER, REV});
        busy_on <= 1'h0;
        wr(CMD_SOFT_RST, 1, 16'h55);
        m_err = m_err | 1;
        m_int = m_int | 8;
        check(16'(sw_cnt), 16'h0, "reset without key");
        rd_int();
        rd_err();
        wr(CMD_SOFT_RST, 1, 16'(RST_KEY));
        m_int = m_int | 8'h10;
        check(16'(sw_cnt), 16'h1, "keyed reset");
        check({cfg, 7'h0, irq_o}, {CFG_RESET, 8'h0}, "state after soft reset");
        rd_int();
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk);
            halt_enter <= 1'h1;
            @(posedge sys_clk);
            halt_enter <= 1'h0;
            repeat (4) @(posedge sys_clk);
            check(16'(core_halted), 16'h1, "halted");
            if (k == 0)
                xfer(dev, CMD_INT_RD, 0, 16'h0, 1, rd, ok);
            else begin
                host.start_cond();
                host.wr_byte(8'h01, ok);
                host.stop_cond();
                repeat (10) @(posedge sys_clk);
            end
            check(16'(ok), 16'h0, "wake cycle acked");
            rd_int();
            check(16'(ok), 16'h1, "retry acked");
        end
        print_verdict();
    end
endmodule

bind hcsu_core hcsu_core_props #(.GPIO_W(GPIO_W)) u_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_o(sda_o), .sda_oe(sda_oe), .evt(evt), .core_busy(core_busy),
    .core_halted(core_halted), .gpio_o(gpio_o), .gpio_oe(gpio_oe),
    .gpio_pull_en(gpio_pull_en), .irq_o(irq_o), .irq_oe(irq_oe), .cfg(cfg),
    .sw_reset(sw_reset));
